// ===== sbc_pkg.sv
// Shared constants and types for the serial control and status link.
//------------------------------------------------------------------
//------------------------------------------------------------------
package sbc_pkg;
  localparam int WORD_W = 16;
  localparam int MON_N = 5;
  // Control word layout
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CFG_SEL_LSB = 3;
  localparam int CFG_SEL_W = 2;
  localparam int CFG_LSB = 5;
  localparam int CYC_CODE_W = 5;
  localparam int CYC_UNUSED_LSB = 10;
  localparam int WD_CODE_W = 6;
  localparam int WD_ZERO_BIT = 11;
  localparam int WD_UNUSED_LSB = 12;
  localparam int UNUSED_MSB = 13;
  localparam int WD_STOP_BIT = 15;
  localparam int SW_SUPPLY_BIT = 5;
  localparam int SW_LED_BIT = 6;
  localparam int SW_LS1_BIT = 8;
  localparam int SW_LS2_BIT = 9;
  localparam logic [1:0] CFG_GENERAL = 2'h0;
  localparam logic [1:0] CFG_SWITCH = 2'h1;
  localparam logic [1:0] CFG_CYCLIC = 2'h2;
  localparam logic [1:0] CFG_WATCHDOG = 2'h3;
  // Mode codes; standby uses a reserved code internally
  localparam logic [2:0] MODE_STANDBY = 3'h0;
  localparam logic [2:0] MODE_ACT_BUS_SLEEP = 3'h2;
  localparam logic [2:0] MODE_ACTIVE = 3'h3;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_RX_ONLY = 3'h6;
  localparam logic [2:0] MODE_STOP = 3'h7;
  // Status word layout
  localparam int ST_PREWARN = 0;
  localparam int ST_LED = 1;
  localparam int ST_VINT = 2;
  localparam int ST_LS = 3;
  localparam int ST_WDR = 4;
  localparam int ST_MON_LSB = 5;
  localparam int ST_BUS = 11;
  localparam int ST_VBAT_UV = 12;
  localparam int ST_VBAT_OV = 13;
  localparam int ST_SUPPLY = 14;
  localparam int ST_VS_UV = 15;
  // Timing
  localparam int PERIOD_STEP_MS = 16;
  localparam int CLK_MHZ = 100;
  localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
  localparam int VMON_STARTUP_US = 100;
  localparam int VMON_STARTUP_CYCLES = VMON_STARTUP_US * CLK_MHZ;
  localparam int SCLK_HALF_CYCLES = 4;
  // Controller register map
  localparam logic [11:0] OFS_TX = 12'h000;
  localparam logic [11:0] OFS_RX = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_ERR = 12'h00c;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_VS_CONFIRM = 2;
  localparam int STAT_DEV_ERR = 3;
  localparam int ERR_DRIVE = 0;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LEAD = 2'b01,
    H_RUN = 2'b10,
    H_TAIL = 2'b11
  } host_state_t;
endpackage

// ===== sbc_link_if.sv
// Serial link and error interconnect between controller and device.
`timescale 1ns/1ps
interface sbc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic mcu_err;
  logic dev_err;

  modport device (
    input sclk,
    input cs_n,
    input mosi,
    input mcu_err,
    output miso,
    output dev_err
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    output mcu_err,
    input miso,
    input dev_err
  );
endinterface

// ===== spi_shift.sv
// Parallel-load shift register, least significant bit leaves first.
`timescale 1ns/1ps
module spi_shift import sbc_pkg::*; #(
  parameter int W = WORD_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic shift,
  input wire logic din,
  // Contents
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] data;
  } shift_state_t;

  shift_state_t s;
  shift_state_t n;

  always_comb begin
    n = s;
    if (load) begin
      n.data = load_val;
    end else if (shift) begin
      n.data = {din, s.data[W-1:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.data;
endmodule

// ===== sbc_device_end.sv
// Device end: control word decode, status word and protection latches.
`timescale 1ns/1ps
module sbc_device_end import sbc_pkg::*; #(
  parameter int MS_CYC = CYCLES_PER_MS,
  parameter int VMON_CYC = VMON_STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  sbc_link_if.device lnk,
  // Fault and supply inputs
  input wire logic vcc_prewarn,
  input wire logic led_fault,
  input wire logic ls_fault,
  input wire logic supply_fault,
  input wire logic vint_uv,
  input wire logic bus_fail,
  input wire logic vbat_uv,
  input wire logic vbat_ov,
  input wire logic vs_uv,
  input wire logic reg_overtemp,
  input wire logic vcc_below_rt,
  input wire logic vcc_current_low,
  input wire logic wd_fail,
  // Monitor and wake inputs
  input wire logic [MON_N-1:0] monitor_level,
  input wire logic [MON_N-1:0] monitor_wake,
  input wire logic bus_wake,
  // Decoded settings and controls
  output logic [2:0] mode,
  output logic cyclic_enable,
  output logic [9:0] cyclic_period_ms,
  output logic wd_period_valid,
  output logic [10:0] wd_period_ms,
  output logic wd_enabled,
  output logic [1:0] low_side_switches,
  output logic high_side_lamp_driver,
  output logic supply_on,
  output logic main_regulator,
  output logic reset_out_n
);
  localparam int DIV_W = $clog2(MS_CYC + 1);
  localparam int VMON_W = $clog2(VMON_CYC + 1);

  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic in_frame;
    logic [4:0] nbits;
    logic miso;
    logic [2:0] mode;
    logic wd_stop_cfg;
    logic [CYC_CODE_W-1:0] cyc_code;
    logic [WD_CODE_W-1:0] wd_code;
    logic supply_en;
    logic led_en;
    logic [1:0] ls_en;
    logic prewarn;
    logic led_f;
    logic ls_f;
    logic supply_f;
    logic wdr;
    logic vint_ok;
    logic vbat_uv;
    logic vbat_ov;
    logic vs_uv;
    logic vs_uv_prev;
    logic snap_vs;
    logic [MON_N-1:0] wake_mon;
    logic wake_bus;
    logic wake_cyc;
    logic woke;
    logic [DIV_W-1:0] ms_div;
    logic [9:0] ms_cnt;
    logic [VMON_W-1:0] vmon_cnt;
    logic vmon_ready;
    logic reg_on;
    logic rst_out_n;
    logic wd_en;
  } dev_state_t;

  dev_state_t s;
  dev_state_t n;
  logic [WORD_W-1:0] sh_q;
  logic sel;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic frame_end;
  logic mon_active;
  logic vmon_valid;
  logic power_saving;
  logic [9:0] cyc_ms;
  logic [WORD_W-1:0] status_now;

  assign sel = ~lnk.cs_n;
  assign sclk_rise = lnk.sclk & ~s.sclk_q;
  assign sclk_fall = ~lnk.sclk & s.sclk_q;
  assign cs_fall = sel & s.cs_q;
  assign frame_end = lnk.cs_n & s.in_frame;
  assign mon_active = (s.mode == MODE_ACTIVE) || (s.mode == MODE_ACT_BUS_SLEEP) ||
                      (s.mode == MODE_RX_ONLY);
  assign vmon_valid = mon_active & s.vmon_ready;
  assign power_saving = (s.mode == MODE_SLEEP) || (s.mode == MODE_STOP);
  assign cyc_ms = 10'(s.cyc_code) * 10'(PERIOD_STEP_MS);

  //------------------------------------------------------------------
  // Status word
  //------------------------------------------------------------------
  function automatic logic [WORD_W-1:0] build_status(input dev_state_t st,
                                                     input logic valid,
                                                     input logic [MON_N-1:0] lvl,
                                                     input logic bfail);
    logic [WORD_W-1:0] w;
    w = '0;
    w[ST_PREWARN] = st.prewarn;
    w[ST_LED] = st.led_f;
    w[ST_VINT] = st.vint_ok;
    w[ST_LS] = st.ls_f;
    w[ST_WDR] = st.wdr;
    w[ST_SUPPLY] = st.supply_f;
    if (st.woke) begin
      w[ST_MON_LSB +: MON_N] = st.wake_mon;
      w[ST_BUS] = st.wake_bus;
      w[ST_VBAT_UV] = st.wake_cyc;
    end else begin
      w[ST_MON_LSB +: MON_N] = lvl;
      w[ST_BUS] = bfail;
      w[ST_VBAT_UV] = st.vbat_uv & valid;
      w[ST_VBAT_OV] = st.vbat_ov & valid;
      w[ST_VS_UV] = st.vs_uv & st.vs_uv_prev & valid;
    end
    return w;
  endfunction

  // One copy of the word feeds both the first bit and the shifter load
  assign status_now = build_status(s, vmon_valid, monitor_level, bus_fail);

  //------------------------------------------------------------------
  // Next state
  //------------------------------------------------------------------
  always_comb begin
    n = s;
    n.sclk_q = lnk.sclk;
    n.cs_q = lnk.cs_n;
    n.reg_on = ~reg_overtemp;
    n.rst_out_n = ~vcc_below_rt;
    n.wd_en = (s.mode == MODE_STOP) ? ~(vcc_current_low & ~s.wd_stop_cfg) : 1'b1;

    // Frame handling: status loaded as the select falls
    if (cs_fall) begin
      n.in_frame = 1'b1;
      n.nbits = '0;
      n.miso = status_now[0];
      n.snap_vs = s.vs_uv;
    end else if (sel) begin
      if (sclk_rise && s.nbits != 5'(WORD_W)) begin
        n.nbits = s.nbits + 5'h01;
      end
      if (sclk_fall) begin
        n.miso = sh_q[0];
      end
    end

    if (frame_end) begin
      n.in_frame = 1'b0;
      n.miso = 1'b0;
      // Read-out clears the latches; sets below still win
      n.prewarn = 1'b0;
      n.wdr = 1'b0;
      n.led_f = 1'b0;
      n.ls_f = 1'b0;
      n.supply_f = 1'b0;
      n.vbat_uv = 1'b0;
      n.vbat_ov = 1'b0;
      n.vs_uv = 1'b0;
      n.vs_uv_prev = s.snap_vs;
      n.vint_ok = 1'b1;
      n.woke = 1'b0;
      n.wake_mon = '0;
      n.wake_bus = 1'b0;
      n.wake_cyc = 1'b0;
      // Short frames are read-outs only; long frames saturate the bit count at 16 and still act as commands
      if (s.nbits == 5'(WORD_W)) begin
        n.mode = sh_q[MODE_LSB +: MODE_W];
        n.wd_stop_cfg = sh_q[WD_STOP_BIT];
        case (sh_q[CFG_SEL_LSB +: CFG_SEL_W])
          CFG_CYCLIC: begin
            n.cyc_code = sh_q[CFG_LSB +: CYC_CODE_W];
          end
          CFG_WATCHDOG: begin
            if (!sh_q[WD_ZERO_BIT] && sh_q[CFG_LSB +: WD_CODE_W] != '0) begin
              n.wd_code = sh_q[CFG_LSB +: WD_CODE_W];
            end
          end
          CFG_SWITCH: begin
            n.supply_en = sh_q[SW_SUPPLY_BIT];
            n.led_en = sh_q[SW_LED_BIT];
            n.ls_en = {sh_q[SW_LS2_BIT], sh_q[SW_LS1_BIT]};
          end
          default: begin
          end
        endcase
      end
    end

    // Cyclic wake timer, stop mode only
    if (s.mode == MODE_STOP && s.cyc_code != '0) begin
      if (s.ms_div == DIV_W'(MS_CYC - 1)) begin
        n.ms_div = '0;
        if (s.ms_cnt + 10'h001 == cyc_ms) begin
          n.ms_cnt = '0;
          n.wake_cyc = 1'b1;
          n.woke = 1'b1;
        end else begin
          n.ms_cnt = s.ms_cnt + 10'h001;
        end
      end else begin
        n.ms_div = s.ms_div + DIV_W'(1);
      end
    end else begin
      n.ms_div = '0;
      n.ms_cnt = '0;
    end

    // Voltage monitor start-up, restarts whenever monitoring stops
    if (!mon_active) begin
      n.vmon_cnt = '0;
      n.vmon_ready = 1'b0;
    end else if (s.vmon_cnt == VMON_W'(VMON_CYC)) begin
      n.vmon_ready = 1'b1;
    end else begin
      n.vmon_cnt = s.vmon_cnt + VMON_W'(1);
    end

    // Wake sources only count while power saving
    if (power_saving && (monitor_wake != '0 || bus_wake)) begin
      n.wake_mon = n.wake_mon | monitor_wake;
      n.wake_bus = n.wake_bus | bus_wake;
      n.woke = 1'b1;
    end

    // Event latches and shutdowns override any command
    if (vcc_prewarn) begin
      n.prewarn = 1'b1;
    end
    if (wd_fail) begin
      n.wdr = 1'b1;
      n.mode = MODE_STANDBY;
    end
    if (led_fault) begin
      n.led_f = 1'b1;
      n.led_en = 1'b0;
    end
    if (ls_fault) begin
      n.ls_f = 1'b1;
      n.ls_en = 2'h0;
    end
    if (lnk.mcu_err) begin
      n.ls_en = 2'h0;
    end
    if (supply_fault) begin
      n.supply_f = 1'b1;
      n.supply_en = 1'b0;
    end
    if (vmon_valid && vbat_uv) begin
      n.vbat_uv = 1'b1;
    end
    if (vmon_valid && vbat_ov) begin
      n.vbat_ov = 1'b1;
    end
    if (vmon_valid && vs_uv) begin
      n.vs_uv = 1'b1;
    end

    // Internal undervoltage wipes every setting and flag
    if (vint_uv) begin
      n = '0;
      n.sclk_q = lnk.sclk;
      n.cs_q = lnk.cs_n;
      n.reg_on = ~reg_overtemp;
      n.wd_en = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cs_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  spi_shift #(
    .W(WORD_W)
  ) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .load(cs_fall),
    .load_val(status_now),
    .shift(sel & sclk_rise),
    .din(lnk.mosi),
    .q(sh_q)
  );

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  assign lnk.miso = s.miso;
  assign lnk.dev_err = s.ls_f;
  assign mode = s.mode;
  assign cyclic_enable = (s.cyc_code != '0);
  assign cyclic_period_ms = cyc_ms;
  assign wd_period_valid = (s.wd_code != '0);
  assign wd_period_ms = 11'(s.wd_code) * 11'(PERIOD_STEP_MS);
  assign wd_enabled = s.wd_en;
  assign low_side_switches = s.ls_en;
  assign high_side_lamp_driver = s.led_en;
  assign supply_on = s.supply_en;
  assign main_regulator = s.reg_on;
  assign reset_out_n = s.rst_out_n;
endmodule

// ===== sbc_host_end.sv
// Controller end: APB registers driving 16-bit full-duplex frames.
`timescale 1ns/1ps
module sbc_host_end import sbc_pkg::*; #(
  parameter int HALF = SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  sbc_link_if.host lnk
);
  typedef struct packed {
    host_state_t state;
    logic [7:0] cnt;
    logic [4:0] edges;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic done;
    logic vs_confirm;
    logic err_drive;
    logic [31:0] rdata;
    logic slverr;
  } host_state_s_t;

  host_state_s_t s;
  host_state_s_t n;
  logic [WORD_W-1:0] sh_q;
  logic [WORD_W-1:0] tx_fixed;
  logic busy;
  logic tick;
  logic start;
  logic host_shift;

  // Clean a control word before it goes out
  function automatic logic [WORD_W-1:0] fix_word(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] f;
    f = w;
    if (w[CFG_SEL_LSB +: CFG_SEL_W] == CFG_CYCLIC) begin
      f[UNUSED_MSB:CYC_UNUSED_LSB] = '0;
    end
    if (w[CFG_SEL_LSB +: CFG_SEL_W] == CFG_WATCHDOG) begin
      f[WD_ZERO_BIT] = 1'b0;
      f[UNUSED_MSB:WD_UNUSED_LSB] = '0;
    end
    return f;
  endfunction

  assign tx_fixed = fix_word(pwdata[WORD_W-1:0]);
  assign busy = (s.state != H_IDLE);
  assign tick = (s.cnt == 8'(HALF - 1));
  assign start = psel & penable & pwrite & ~s.slverr & (paddr == OFS_TX);
  assign host_shift = tick & ~s.sclk & (s.state == H_LEAD || s.state == H_RUN);

  always_comb begin
    n = s;
    // Read data and error decided in the setup cycle
    if (psel && !penable) begin
      n.rdata = '0;
      n.slverr = 1'b0;
      case (paddr)
        OFS_TX: begin
          n.rdata = {16'h0000, s.tx};
          if (pwrite && (busy || (pwdata[CFG_SEL_LSB +: CFG_SEL_W] == CFG_WATCHDOG &&
              pwdata[CFG_LSB +: WD_CODE_W] == '0))) begin
            n.slverr = 1'b1;
          end
        end
        OFS_RX: begin
          n.rdata = {16'h0000, s.rx};
        end
        OFS_STAT: begin
          n.rdata[STAT_BUSY] = busy;
          n.rdata[STAT_DONE] = s.done;
          n.rdata[STAT_VS_CONFIRM] = s.vs_confirm;
          n.rdata[STAT_DEV_ERR] = lnk.dev_err;
        end
        OFS_ERR: begin
          n.rdata[ERR_DRIVE] = s.err_drive;
        end
        default: begin
          n.slverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && !s.slverr) begin
      if (paddr == OFS_STAT && pwdata[STAT_DONE]) begin
        n.done = 1'b0;
      end
      if (paddr == OFS_ERR) begin
        n.err_drive = pwdata[ERR_DRIVE];
      end
    end

    // Frame sequencer
    n.cnt = (busy && !tick) ? s.cnt + 8'h01 : 8'h00;
    case (s.state)
      H_IDLE: begin
        if (start) begin
          n.tx = tx_fixed;
          n.state = H_LEAD;
          n.cs_n = 1'b0;
          n.edges = '0;
          n.mosi = tx_fixed[0];
        end
      end
      H_LEAD: begin
        if (tick) begin
          n.sclk = 1'b1;
          n.edges = s.edges + 5'h01;
          n.state = H_RUN;
        end
      end
      H_RUN: begin
        if (tick) begin
          if (s.sclk) begin
            n.sclk = 1'b0;
            if (s.edges == 5'(WORD_W)) begin
              n.state = H_TAIL;
            end else begin
              n.mosi = sh_q[0];
            end
          end else begin
            n.sclk = 1'b1;
            n.edges = s.edges + 5'h01;
          end
        end
      end
      H_TAIL: begin
        if (tick) begin
          n.cs_n = 1'b1;
          n.mosi = 1'b0;
          n.state = H_IDLE;
          n.rx = sh_q;
          n.done = 1'b1;
          n.vs_confirm = sh_q[ST_VS_UV] & s.rx[ST_VS_UV];
        end
      end
      default: begin
        n.state = H_IDLE;
        n.cs_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cs_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  spi_shift #(
    .W(WORD_W)
  ) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .load(start & ~busy),
    .load_val(tx_fixed),
    .shift(host_shift),
    .din(lnk.miso),
    .q(sh_q)
  );

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.slverr;
  assign lnk.sclk = s.sclk;
  assign lnk.cs_n = s.cs_n;
  assign lnk.mosi = s.mosi;
  assign lnk.mcu_err = s.err_drive;
endmodule

// ===== sbc_link_sva.sv
// Wire-level checker for the serial link between the two ends.
`timescale 1ns/1ps
module sbc_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------
  // Rising serial clock edges in the current frame
  // ----------
  logic sclk_d;
  logic [4:0] rises;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b0;
      rises <= 5'h00;
    end else begin
      sclk_d <= sclk;
      if (cs_n) begin
        rises <= 5'h00;
      end else if (sclk && !sclk_d) begin
        rises <= rises + 5'h01;
      end
    end
  end

  sequence s_lead;
    !sclk [*4] ##1 sclk;
  endsequence
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence

  a_lead_time: assert property ($fell(cs_n) |-> s_lead)
    else $error("serial clock lead after select is wrong");
  a_high_half: assert property ($rose(sclk) |-> s_high)
    else $error("serial clock high phase has wrong length");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  a_select_gap: assert property ($rose(cs_n) |=> cs_n)
    else $error("select high time between frames too short");
  a_sixteen_rises: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("control bit changed while clock high");
  a_miso_hold: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("status bit changed while clock high");
endmodule

// ===== sbc_spi_timing_and_status_word_tb.sv
// Bench joining the controller end and the device end over the link.
`timescale 1ns/1ps
module sbc_spi_timing_and_status_word_tb import sbc_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  // Device fault, supply and wake inputs
  logic [12:0] f = 13'h0;
  logic [4:0] mon = 5'h00;
  logic [4:0] mwk = 5'h00;
  logic bwk = 1'b0;
  logic [2:0] mode;
  logic cen;
  logic [9:0] cper;
  logic wval;
  logic [10:0] wper;
  logic wden;
  logic [1:0] lss;
  logic lamp;
  logic son;
  logic mreg;
  logic rstn;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 pclk = ~pclk;

  sbc_link_if lnk();
  sbc_host_end #(.HALF(4)) sbc_host_end_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(lnk)
  );
  // Short millisecond keeps cyclic wake within a few frames
  sbc_device_end #(.MS_CYC(4), .VMON_CYC(8)) sbc_device_end_i (
    .pclk(pclk), .presetn(presetn), .lnk(lnk),
    .vcc_prewarn(f[0]), .led_fault(f[1]), .ls_fault(f[2]), .supply_fault(f[3]),
    .vint_uv(f[4]), .bus_fail(f[5]), .vbat_uv(f[6]), .vbat_ov(f[7]), .vs_uv(f[8]),
    .reg_overtemp(f[9]), .vcc_below_rt(f[10]), .vcc_current_low(f[11]), .wd_fail(f[12]),
    .monitor_level(mon), .monitor_wake(mwk), .bus_wake(bwk), .mode(mode),
    .cyclic_enable(cen), .cyclic_period_ms(cper), .wd_period_valid(wval),
    .wd_period_ms(wper), .wd_enabled(wden), .low_side_switches(lss),
    .high_side_lamp_driver(lamp), .supply_on(son), .main_regulator(mreg), .reset_out_n(rstn)
  );
  sbc_link_sva sbc_link_sva_i (
    .pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso(lnk.miso)
  );

  // ----------
  // Shared tasks
  // ----------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task test_done;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] cw(logic [2:0] m, logic [1:0] s, logic [8:0] v);
    return {2'b00, v, s, m};
  endfunction

  // Sends one word, waits for done, clears it and fetches the status
  task frame(input logic [15:0] w);
    apb(1'b1, OFS_TX, {16'h0, w});
    do apb(1'b0, OFS_STAT, 32'h0); while (rd[STAT_DONE] !== 1'b1);
    apb(1'b1, OFS_STAT, 32'h2);
    apb(1'b0, OFS_RX, 32'h0);
  endtask

  task pulse(input logic [12:0] m);
    f <= f | m;
    @(posedge pclk);
    f <= f & ~m;
    repeat (3) @(posedge pclk);
  endtask

  // ----------
  // Scenarios
  // ----------
  task t_idle;
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    f[10:9] <= 2'b11;
    repeat (3) @(posedge pclk);
    chk("regulator off", mreg, 0);
    chk("reset out", rstn, 0);
    f[10:9] <= 2'b00;
    repeat (3) @(posedge pclk);
    chk("regulator back", mreg, 1);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("supply ok bit", rd[ST_VINT], 0);
    chk("mode", mode, MODE_ACTIVE);
  endtask

  task t_cyc;
    logic [4:0] cc [3] = '{5'h00, 5'h01, 5'h1f};
    foreach (cc[i]) begin
      frame(cw(MODE_ACTIVE, CFG_CYCLIC, {4'hf, cc[i]}));
      chk("cyc enable", cen, cc[i] != 5'h00);
      chk("cyc period", cper, cc[i] * PERIOD_STEP_MS);
      apb(1'b0, OFS_TX, 32'h0);
      chk("cyc word", rd, cw(MODE_ACTIVE, CFG_CYCLIC, {4'h0, cc[i]}));
    end
  endtask

  task t_wd;
    logic [5:0] cc [2] = '{6'h01, 6'h3f};
    foreach (cc[i]) begin
      frame(cw(MODE_ACTIVE, CFG_WATCHDOG, {3'h7, cc[i]}));
      chk("wd valid", wval, 1);
      chk("wd period", wper, cc[i] * PERIOD_STEP_MS);
    end
    apb(1'b1, OFS_TX, cw(MODE_ACTIVE, CFG_WATCHDOG, 9'h0));
    chk("wd zero refused", er, 1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("no frame", rd[STAT_BUSY], 0);
    chk("wd kept", wper, 11'd1008);
  endtask

  task t_status;
    frame(cw(MODE_ACTIVE, CFG_SWITCH, 9'h01b));
    chk("switches on", lss, 2'h3);
    chk("lamp on", lamp, 1);
    mon <= 5'h15;
    f[5] <= 1'b1;
    // Let the level land before the pulse rewrites the whole vector
    @(posedge pclk);
    pulse(13'h000f);
    chk("switches off", lss, 0);
    chk("lamp off", lamp, 0);
    chk("supply off", son, 0);
    chk("error pin", lnk.dev_err, 1);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("status", rd, 32'h4aaf);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("status read", rd, 32'h0aa4);
    chk("still off", lss, 0);
    frame(cw(MODE_ACTIVE, CFG_SWITCH, 9'h018));
    chk("switches back", lss, 2'h3);
    apb(1'b1, OFS_ERR, 32'h1);
    repeat (3) @(posedge pclk);
    chk("error input", lss, 0);
    apb(1'b1, OFS_ERR, 32'h0);
    chk("stays off", lss, 0);
  endtask

  task t_vmon;
    f[8:5] <= 4'he;
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("vs first read", rd[ST_VS_UV], 0);
    chk("vbat uv", rd[ST_VBAT_UV], 1);
    chk("vbat ov", rd[ST_VBAT_OV], 1);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("vs second read", rd[ST_VS_UV], 1);
    f[8:6] <= 3'h0;
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    apb(1'b0, OFS_STAT, 32'h0);
    chk("vs confirmed", rd[STAT_VS_CONFIRM], 1);
  endtask

  task t_wdf;
    pulse(13'h1000);
    chk("standby", mode, MODE_STANDBY);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("wd flag", rd[ST_WDR], 1);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("wd flag cleared", rd[ST_WDR], 0);
    pulse(13'h0010);
    chk("vint wipe", {wval, mode}, 0);
    frame(cw(MODE_ACTIVE, CFG_GENERAL, 9'h0));
    chk("vint fail bit", rd[ST_VINT], 0);
  endtask

  task t_wake;
    frame(cw(MODE_ACTIVE, CFG_CYCLIC, 9'h001));
    f[11] <= 1'b1;
    frame(cw(MODE_STOP, CFG_GENERAL, 9'h0));
    chk("stop", mode, MODE_STOP);
    chk("wd off in stop", wden, 0);
    repeat (100) @(posedge pclk);
    mwk <= 5'h02;
    bwk <= 1'b1;
    @(posedge pclk);
    mwk <= 5'h00;
    bwk <= 1'b0;
    frame(cw(MODE_ACTIVE, CFG_CYCLIC, 9'h0));
    chk("wake status", rd, 32'h1844);
    chk("wd on", wden, 1);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle;
    t_cyc;
    t_wd;
    t_status;
    t_vmon;
    t_wdf;
    t_wake;
    test_done;
  end

  // Far above the roughly 3000 cycles the scenarios need
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule
